// ===== inc/setpoint_pkg.sv
// Purpose: Constants for the up/down speed-offset block
// Assumes: 250 MHz pclk, APB register access, speeds in rpm
// Notes:   Behaviour list below; the design implements each item
//
// Behaviour
// - Mode 0..6, zero disables, default zero
// - Raise/lower offset, clamp to rated times percent
// - Offset changes linearly, jumps only on clear, restore or lowered limit
// - Modes 2,4,6: both inputs zero offset
// - Modes 3,4: save offset on mains fail
// - Modes 5,6: start withdrawn clears offset
// - Rise rate 0..32760 rpm/s, default 1000
// - Fall rate same range, default 1000
// - Offset readback signed rpm, zero after reset
// - Offset added to analog base speed
`default_nettype none

package setpoint_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_MODE       = 8'h00;
    localparam logic [7:0]  ADDR_RISE       = 8'h04;
    localparam logic [7:0]  ADDR_FALL       = 8'h08;
    localparam logic [7:0]  ADDR_OFFSET     = 8'h0C;
    localparam logic [7:0]  ADDR_RATED      = 8'h10;
    localparam logic [7:0]  ADDR_PERCENT    = 8'h14;
    localparam logic [7:0]  ADDR_STATUS     = 8'h18;

    localparam logic [15:0] MODE_RESET      = 16'h0000;
    localparam logic [15:0] RATE_RESET      = 16'h03E8;
    localparam logic [15:0] RATED_RESET     = 16'h0BB8;
    localparam logic [15:0] PERCENT_RESET   = 16'h0064;

    // ------------------------------------------------------------
    // Modes and ranges
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_OFF        = 3'h0;
    localparam logic [2:0]  MODE_LAST       = 3'h6;
    localparam logic [15:0] RATE_MAX        = 16'h7FF8;
    localparam logic [15:0] SPEED_MAX       = 16'h7FFC;
    localparam logic [31:0] PERCENT_DIV     = 32'h0000_0064;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          NS_PER_S        = 1000000000;
    localparam int          ACC_W           = 28;
    localparam logic [ACC_W-1:0] CYCLES_PER_S = ACC_W'(NS_PER_S / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

endpackage

`default_nettype wire

// ===== inc/ramp_if.sv
// Purpose: Link between offset control and one ramp stepper
// Assumes: Same clock domain on both sides
// Notes:   One instance per ramp direction
`default_nettype none

interface ramp_if;
    logic        enable;
    logic [15:0] rate;
    logic        step;

    modport ctrl (output enable, output rate, input step);
    modport stepper (input enable, input rate, output step);
endinterface

`default_nettype wire

// ===== hw/ramp_step.sv
// Purpose: Rate accumulator giving one-rpm step pulses
// Assumes: Rate in rpm per second, pclk at the package rate
// Notes:   Accumulator restarts when disabled
`default_nettype none

module ramp_step
    import setpoint_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Ramp link
    ramp_if.stepper   rp
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic             step_q;
    logic             step_d;

    // ------------------------------------------------------------
    // Fractional rpm accumulation
    // ------------------------------------------------------------
    always_comb begin
        acc_d  = '0;
        step_d = 1'b0;
        if (rp.enable) begin
            // Sum stays below 2^28 since rate never exceeds RATE_MAX
            acc_d = acc_q + ACC_W'(rp.rate);
            if (acc_d >= CYCLES_PER_S) begin
                acc_d  = acc_d - CYCLES_PER_S;
                step_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q  <= '0;
            step_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            step_q <= step_d;
        end
    end

    assign rp.step = step_q;

endmodule

`default_nettype wire

// ===== hw/setpoint_updown_offset.sv
// Purpose: Digital speed potentiometer offset on an analog base speed
// Assumes: Inputs synchronous to pclk, APB slave with one wait state
// Notes:   Retained storage lives outside; save and restore by strobes
`default_nettype none

module setpoint_updown_offset
    import setpoint_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Terminal inputs
    input  wire logic        raise_input,
    input  wire logic        lower_input,
    input  wire logic        start_cmd,
    input  wire logic        mains_fail,
    // Analog base speed
    input  wire logic [15:0] analog_base_input,
    // Retained storage
    input  wire logic        retain_valid,
    input  wire logic [15:0] retain_value,
    output logic             retain_wr,
    output logic [15:0]      retain_data,
    // Speed outputs
    output logic [15:0]      offset_speed_value,
    output logic [15:0]      speed_setpoint
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_state_t         bus_q, bus_d;
    logic [31:0]        prdata_q, prdata_d;
    logic               pslverr_q, pslverr_d;
    logic [2:0]         mode_q, mode_d;
    logic [15:0]        rise_q, rise_d;
    logic [15:0]        fall_q, fall_d;
    logic [15:0]        rated_q, rated_d;
    logic [15:0]        pct_q, pct_d;
    logic [15:0]        limit_q, limit_d;
    logic signed [15:0] offset_q, offset_d;
    logic [15:0]        setpoint_q, setpoint_d;
    logic               start_q, start_d;
    logic               fail_q, fail_d;
    logic               rwr_q, rwr_d;
    logic [15:0]        rdata_q, rdata_d;
    logic               wr_ok;
    logic               rd_ok;
    logic               mapped;
    logic               mode_clr_both;
    logic               mode_retain;
    logic               mode_start;
    logic               only_up;
    logic               only_dn;
    logic               at_limit;
    logic [1:0]         steps;

    ramp_if rr[2] ();

    // ------------------------------------------------------------
    // Ramp steppers, one per direction
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_ramp
            ramp_step u_ramp (
                .pclk    (pclk),
                .presetn (presetn),
                .rp      (rr[i])
            );
            assign steps[i] = rr[i].step;
        end
    endgenerate

    assign only_up        = raise_input && !lower_input;
    assign only_dn        = lower_input && !raise_input;
    assign rr[0].enable   = only_up && (mode_q != MODE_OFF);
    assign rr[0].rate     = rise_q;
    assign rr[1].enable   = only_dn && (mode_q != MODE_OFF);
    assign rr[1].rate     = fall_q;

    // Mode classes
    assign mode_clr_both  = (mode_q == 3'h2) || (mode_q == 3'h4) || (mode_q == 3'h6);
    assign mode_retain    = (mode_q == 3'h3) || (mode_q == 3'h4);
    assign mode_start     = (mode_q == 3'h5) || (mode_q == 3'h6);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign mapped = (paddr == ADDR_MODE) || (paddr == ADDR_RISE) ||
                    (paddr == ADDR_FALL) || (paddr == ADDR_OFFSET) ||
                    (paddr == ADDR_RATED) || (paddr == ADDR_PERCENT) ||
                    (paddr == ADDR_STATUS);
    // Writes land only at the edge where pready is seen high
    assign wr_ok  = psel && penable && pready_q_w() && pwrite && !pslverr_q;
    assign rd_ok  = psel && penable && (bus_q == BUS_IDLE) && !pwrite;

    function automatic logic pready_q_w();
        return bus_q == BUS_DONE;
    endfunction

    always_comb begin
        bus_d     = bus_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        case (bus_q)
            BUS_IDLE: begin
                if (psel && penable) begin
                    bus_d     = BUS_DONE;
                    pslverr_d = !mapped || (pwrite && (paddr == ADDR_OFFSET ||
                                                      paddr == ADDR_STATUS));
                    prdata_d  = '0;
                    if (rd_ok) begin
                        case (paddr)
                            ADDR_MODE:    prdata_d = {29'h0, mode_q};
                            ADDR_RISE:    prdata_d = {16'h0, rise_q};
                            ADDR_FALL:    prdata_d = {16'h0, fall_q};
                            ADDR_OFFSET:  prdata_d = {{16{offset_q[15]}}, offset_q};
                            ADDR_RATED:   prdata_d = {16'h0, rated_q};
                            ADDR_PERCENT: prdata_d = {16'h0, pct_q};
                            ADDR_STATUS:  prdata_d = {29'h0, at_limit, lower_input,
                                                      raise_input};
                            default:      prdata_d = '0;
                        endcase
                    end
                end
            end
            BUS_DONE: begin
                bus_d     = BUS_IDLE;
                pslverr_d = 1'b0;
                prdata_d  = '0;
            end
            default: begin
                bus_d     = BUS_IDLE;
                pslverr_d = 1'b0;
                prdata_d  = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_q     <= BUS_IDLE;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            bus_q     <= bus_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb begin
        mode_d  = mode_q;
        rise_d  = rise_q;
        fall_d  = fall_q;
        rated_d = rated_q;
        pct_d   = pct_q;
        if (wr_ok) begin
            case (paddr)
                ADDR_MODE: begin
                    // Out-of-range codes are dropped, mode stays valid
                    if (pwdata[31:0] <= 32'(MODE_LAST))
                        mode_d = pwdata[2:0];
                end
                ADDR_RISE:
                    rise_d = (pwdata[15:0] > RATE_MAX) ? RATE_MAX : pwdata[15:0];
                ADDR_FALL:
                    fall_d = (pwdata[15:0] > RATE_MAX) ? RATE_MAX : pwdata[15:0];
                ADDR_RATED:   rated_d = pwdata[15:0];
                ADDR_PERCENT: pct_d   = pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q  <= MODE_RESET[2:0];
            rise_q  <= RATE_RESET;
            fall_q  <= RATE_RESET;
            rated_q <= RATED_RESET;
            pct_q   <= PERCENT_RESET;
        end else begin
            mode_q  <= mode_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
            rated_q <= rated_d;
            pct_q   <= pct_d;
        end
    end

    // ------------------------------------------------------------
    // Speed limit, one cycle behind the configuration
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] prod;
        prod = 32'(rated_q) * 32'(pct_q) / PERCENT_DIV;
        limit_d = (prod > 32'(SPEED_MAX)) ? SPEED_MAX : prod[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) limit_q <= '0;
        else          limit_q <= limit_d;
    end

    // ------------------------------------------------------------
    // Offset speed
    // ------------------------------------------------------------
    assign at_limit = (offset_q >= $signed(limit_q)) || (offset_q <= -$signed(limit_q));

    always_comb begin
        offset_d = offset_q;
        start_d  = start_cmd;
        fail_d   = mains_fail;
        rwr_d    = 1'b0;
        rdata_d  = rdata_q;
        if (mode_q == MODE_OFF) begin
            offset_d = '0;
        end else if (mode_start && start_q && !start_cmd) begin
            offset_d = '0;
        end else if (mode_retain && retain_valid) begin
            offset_d = $signed(retain_value);
        end else if (mode_clr_both && raise_input && lower_input) begin
            offset_d = '0;
        end else if (only_up && steps[0] && (offset_q < $signed(limit_q))) begin
            offset_d = offset_q + 16'sh0001;
        end else if (only_dn && steps[1] && (offset_q > -$signed(limit_q))) begin
            offset_d = offset_q - 16'sh0001;
        end
        // Restored or stale values beyond a lowered limit are pulled in
        if (offset_d > $signed(limit_q))
            offset_d = $signed(limit_q);
        else if (offset_d < -$signed(limit_q))
            offset_d = -$signed(limit_q);
        // Neither or both (modes 1,3,5) leave offset_d as held
        if (mode_retain && mains_fail && !fail_q) begin
            rwr_d   = 1'b1;
            rdata_d = offset_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_q <= '0;
            start_q  <= 1'b0;
            fail_q   <= 1'b0;
            rwr_q    <= 1'b0;
            rdata_q  <= '0;
        end else begin
            offset_q <= offset_d;
            start_q  <= start_d;
            fail_q   <= fail_d;
            rwr_q    <= rwr_d;
            rdata_q  <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Base plus offset
    // ------------------------------------------------------------
    always_comb begin
        logic signed [16:0] sum;
        sum = 17'($signed(analog_base_input)) + 17'(offset_q);
        if (sum > $signed({1'b0, SPEED_MAX}))
            setpoint_d = SPEED_MAX;
        else if (sum < -$signed({1'b0, SPEED_MAX}))
            setpoint_d = 16'(-$signed({1'b0, SPEED_MAX}));
        else
            setpoint_d = sum[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) setpoint_q <= '0;
        else          setpoint_q <= setpoint_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata             = prdata_q;
    assign pready             = bus_q == BUS_DONE;
    assign pslverr            = pslverr_q;
    assign retain_wr          = rwr_q;
    assign retain_data        = rdata_q;
    assign offset_speed_value = offset_q;
    assign speed_setpoint     = setpoint_q;

endmodule

`default_nettype wire

// ===== testbench/setpoint_updown_offset_properties.sv
// Purpose: Port checker for the offset block
// Assumes: Sees only top ports, one clock domain
// Notes:   Mode is not visible here, so mode rules stay in the bench
`default_nettype none

module setpoint_updown_offset_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Terminal and storage
    input wire logic        raise_input,
    input wire logic        lower_input,
    input wire logic        start_cmd,
    input wire logic        mains_fail,
    input wire logic [15:0] analog_base_input,
    input wire logic        retain_valid,
    input wire logic        retain_wr,
    input wire logic [15:0] retain_data,
    // Speeds
    input wire logic [15:0] offset_speed_value,
    input wire logic [15:0] speed_setpoint
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic [15:0] sat(input logic [15:0] b, input logic [15:0] o);
        logic signed [16:0] s;
        s = $signed({b[15], b}) + $signed({o[15], o});
        if (s > 17'sd32764) return 16'h7FFC;
        if (s < -17'sd32764) return 16'h8004;
        return s[15:0];
    endfunction

    property p_ready_req;
        pready |-> psel && penable && $past(psel && penable);
    endproperty
    a_ready_req: assert property (p_ready_req) else $error("pready outside access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_ready;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_range;
        !(offset_speed_value inside {[16'h7FFD:16'h8003]});
    endproperty
    a_range: assert property (p_range) else $error("offset out of range");
    property p_sum;
        $past(presetn) |-> speed_setpoint == sat($past(analog_base_input),
                                                 $past(offset_speed_value));
    endproperty
    a_sum: assert property (p_sum) else $error("setpoint not base plus offset");
    property p_linear;
        $changed(offset_speed_value) && !$past(retain_valid) && !$past(retain_valid, 2)
            |-> offset_speed_value == 16'h0000
             || offset_speed_value == $past(offset_speed_value) + 16'h0001
             || offset_speed_value == $past(offset_speed_value) - 16'h0001;
    endproperty
    a_linear: assert property (p_linear) else $error("offset jumped");
    property p_hold;
        (!raise_input && !lower_input && !psel && !retain_valid && $stable(start_cmd))[*3]
            |=> $stable(offset_speed_value);
    endproperty
    a_hold: assert property (p_hold) else $error("offset moved while idle");
    property p_save;
        retain_wr |-> (($past(mains_fail) && !$past(mains_fail, 2))
                    || ($past(mains_fail, 2) && !$past(mains_fail, 3)))
                   && (retain_data == $past(offset_speed_value)
                    || retain_data == $past(offset_speed_value, 2)) ##1 !retain_wr;
    endproperty
    a_save: assert property (p_save) else $error("bad save pulse");
endmodule

bind setpoint_updown_offset setpoint_updown_offset_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raise_input(raise_input),
    .lower_input(lower_input), .start_cmd(start_cmd), .mains_fail(mains_fail),
    .analog_base_input(analog_base_input), .retain_valid(retain_valid),
    .retain_wr(retain_wr), .retain_data(retain_data),
    .offset_speed_value(offset_speed_value), .speed_setpoint(speed_setpoint));

`default_nettype wire

// ===== testbench/retain_store.sv
// Purpose: Retained storage beside the offset block
// Assumes: Restore requested by the bench
// Notes:   Value line shows inverted data while not valid
`default_nettype none

module retain_store (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Storage link
    input  wire logic        retain_wr,
    input  wire logic [15:0] retain_data,
    input  wire logic        restore_req,
    output logic             retain_valid,
    output logic [15:0]      retain_value
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] stored_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stored_q     <= 16'h0000;
            retain_valid <= 1'b0;
        end else begin
            if (retain_wr) stored_q <= retain_data;
            retain_valid <= restore_req;
        end
    end
    // Stale value would hide a missed valid check
    assign retain_value = retain_valid ? stored_q : ~stored_q;
endmodule

`default_nettype wire

// ===== testbench/setpoint_updown_offset_tb_top.sv
// Purpose: Self-checking bench for the offset block
// Assumes: Rates at maximum so steps come every few thousand cycles
// Notes:   Small speed limits keep clamp cases short
`default_nettype none

module setpoint_updown_offset_tb_top import setpoint_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and helpers
    // ------------------------------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'hDA0BC7C2;
    logic        raise_input = 0, lower_input = 0, start_cmd = 0, mains_fail = 0;
    logic        restore_req = 0, retain_valid, retain_wr, er;
    logic [15:0] analog_base_input = 0, retain_value, retain_data;
    logic [15:0] offset_speed_value, speed_setpoint;
    int          error_cnt = 0, n_compared = 0, n;

    always #2 pclk = ~pclk;

    setpoint_updown_offset dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .raise_input(raise_input),
        .lower_input(lower_input), .start_cmd(start_cmd), .mains_fail(mains_fail),
        .analog_base_input(analog_base_input), .retain_valid(retain_valid),
        .retain_value(retain_value), .retain_wr(retain_wr), .retain_data(retain_data),
        .offset_speed_value(offset_speed_value), .speed_setpoint(speed_setpoint));
    retain_store ret_u (.pclk(pclk), .presetn(presetn), .retain_wr(retain_wr),
        .retain_data(retain_data), .restore_req(restore_req),
        .retain_valid(retain_valid), .retain_value(retain_value));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task test_done;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        // Only the watchdog ends a wait; one wait state means answer at second edge
        do begin @(posedge pclk); k++; end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        chk("wait states", 32'(k), 32'h2);
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(0, a, 32'h0);
        chk(nm, rd, e);
        chk("pslverr", {31'h0, er}, {31'h0, ee});
    endtask
    task off_port(input logic [15:0] e);
        chk("offset", {16'h0, offset_speed_value}, {16'h0, e});
    endtask
    task off_is(input logic [15:0] e);
        cyc(3);
        off_port(e);
        chk("setpoint", {16'h0, speed_setpoint}, {16'h0, analog_base_input + e});
        rdchk("offset reg", ADDR_OFFSET, {{16{e[15]}}, e}, 1'b0);
    endtask
    task lvl(input logic r, input logic l, input int c);
        seed = lfsr(seed);
        analog_base_input <= {{6{seed[9]}}, seed[9:0]};
        raise_input <= r;
        lower_input <= l;
        cyc(c);
    endtask
    task restore;
        restore_req <= 1;
        cyc(1);
        restore_req <= 0;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #360000;
        error_cnt++;
        test_done;
    end
    initial begin
        cyc(5);
        presetn <= 1;
        n = (int'(CYCLES_PER_S) + int'(RATE_MAX) - 1) / int'(RATE_MAX);
        rdchk("mode", ADDR_MODE, {16'h0, MODE_RESET}, 1'b0);
        rdchk("rise", ADDR_RISE, {16'h0, RATE_RESET}, 1'b0);
        rdchk("fall", ADDR_FALL, {16'h0, RATE_RESET}, 1'b0);
        rdchk("offset", ADDR_OFFSET, 32'h0, 1'b0);
        rdchk("unmapped", 8'h1C, 32'h0, 1'b1);
        apb(1, ADDR_OFFSET, 32'h5);
        chk("ro write", {31'h0, er}, 32'h1);
        apb(1, ADDR_RISE, 32'hFFFF);
        rdchk("rise sat", ADDR_RISE, {16'h0, RATE_MAX}, 1'b0);
        apb(1, ADDR_FALL, {16'h0, RATE_MAX});
        apb(1, ADDR_RATED, 32'h3);
        apb(1, ADDR_PERCENT, 32'h32);
        apb(1, ADDR_MODE, 32'h1);
        lvl(1, 0, 2 * n + 5); // Raise only
        off_is(16'h0001); // Clamped at limit one
        rdchk("status", ADDR_STATUS, 32'h5, 1'b0);
        lvl(0, 1, n + 5); // Lower only
        off_port(16'h0000);
        cyc(n);
        off_is(16'hFFFF);
        lvl(1, 1, 100);
        off_is(16'hFFFF);
        lvl(0, 0, 2);
        apb(1, ADDR_MODE, 32'h2);
        lvl(1, 1, 4);
        lvl(0, 0, 1);
        off_is(16'h0000);
        apb(1, ADDR_PERCENT, 32'h64);
        apb(1, ADDR_MODE, 32'h5);
        start_cmd <= 1;
        lvl(1, 0, n + 5);
        lvl(0, 0, 1);
        off_is(16'h0001);
        start_cmd <= 0;
        cyc(4);
        off_is(16'h0000);
        apb(1, ADDR_MODE, 32'h3);
        lvl(1, 0, n + 5);
        lvl(0, 0, 1);
        mains_fail <= 1;
        cyc(4);
        mains_fail <= 0;
        apb(1, ADDR_MODE, 32'h7);
        rdchk("mode keep", ADDR_MODE, 32'h3, 1'b0);
        lvl(0, 1, 2 * n + 5);
        lvl(0, 0, 1);
        off_is(16'hFFFF);
        restore_req <= 1;
        cyc(1);
        restore_req <= 0;
        off_is(16'h0001);
        apb(1, ADDR_MODE, 32'h0);
        off_is(16'h0000);
        apb(1, ADDR_MODE, 32'h4);
        restore;
        off_is(16'h0001);
        mains_fail <= 1;
        cyc(2);
        mains_fail <= 0;
        lvl(1, 1, 4);
        lvl(0, 0, 1);
        off_is(16'h0000);
        restore;
        off_is(16'h0001);
        apb(1, ADDR_MODE, 32'h6);
        start_cmd <= 1;
        cyc(2);
        start_cmd <= 0;
        off_is(16'h0000);
        restore;
        off_is(16'h0000); // Restore ignored outside retain modes
        apb(1, ADDR_MODE, 32'h4);
        restore;
        apb(1, ADDR_MODE, 32'h6);
        lvl(1, 1, 4);
        lvl(0, 0, 1);
        off_is(16'h0000);
        apb(1, ADDR_MODE, 32'h4);
        restore;
        off_is(16'h0001);
        // Mid-run reset with a live offset
        presetn <= 0;
        cyc(2);
        presetn <= 1;
        off_is(16'h0000);
        rdchk("mode rst", ADDR_MODE, {16'h0, MODE_RESET}, 1'b0);
        rdchk("rise rst", ADDR_RISE, {16'h0, RATE_RESET}, 1'b0);
        test_done;
    end
endmodule

`default_nettype wire
